//--- verif/cpu_seq_model.sv
// behavioural cpu sequencer with a small return stack
`timescale 1ns/1ps
`default_nettype none
module cpu_seq_model #(
    parameter int DEPTH = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic pc_load,
    input wire logic [15:0] push_pc,
    input wire logic [15:0] pc_load_value,
    input wire logic do_ret,
    input wire logic slow,
    output logic irq_ready,
    output logic stack_full,
    output logic [15:0] pc_next,
    output logic return_from_irq,
    output logic [15:0] stack_top
);
    logic [15:0] stk [DEPTH];
    int sp;
    logic tick;
    // pc steps each cycle unless a vector or popped address is loaded
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sp <= 0;
            tick <= 1'h0;
            pc_next <= 16'h0100;
        end else begin
            tick <= ~tick;
            pc_next <= pc_load ? pc_load_value : pc_next + 16'h1;
            if (stack_push) stk[sp] <= push_pc;
            sp <= sp + int'(stack_push) - int'(stack_pop);
        end
    end
    // slow mode offers an instruction boundary only every other cycle
    assign irq_ready = ~slow | tick;
    assign stack_full = sp >= DEPTH;
    assign return_from_irq = do_ret;
    assign stack_top = stk[(sp > 0) ? sp - 1 : 0];
endmodule // cpu_seq_model
`default_nettype wire

//--- verif/irq_controller_props.sv
// port-level assertions for the interrupt controller cpu side and bus read data
`timescale 1ns/1ps
`default_nettype none
module irq_controller_props #(
    parameter int PC_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    input wire logic irq_ready,
    input wire logic stack_full,
    input wire logic [PC_W-1:0] pc_next,
    input wire logic return_from_irq,
    input wire logic [PC_W-1:0] stack_top,
    input wire logic sleep_mode,
    input wire logic stack_push,
    input wire logic [PC_W-1:0] push_pc,
    input wire logic stack_pop,
    input wire logic pc_load,
    input wire logic [PC_W-1:0] pc_load_value,
    input wire logic wake_up
);
    localparam int VEC_TOP = irq_ctrl_pkg::VEC_BASE + irq_ctrl_pkg::VEC_STEP * (irq_ctrl_pkg::NUM_SRC - 1);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // entry and return both show as a program counter load
    sequence s_enter;
        stack_push && pc_load;
    endsequence
    sequence s_leave;
        stack_pop && pc_load && !stack_push;
    endsequence
    a_enter_loads: assert property (stack_push |-> s_enter) else $error("push without load");
    a_push_value: assert property (stack_push |-> push_pc == $past(pc_next)) else $error("pushed pc wrong");
    a_return_pops: assert property (return_from_irq |=> s_leave ##0 pc_load_value == $past(stack_top)) else $error("bad return");
    a_pop_cause: assert property (stack_pop |-> $past(return_from_irq)) else $error("pop without return");
    a_full_blocks: assert property (stack_full |=> !stack_push) else $error("take with full stack");
    a_ready_gates: assert property (!irq_ready |=> !stack_push) else $error("take off boundary");
    a_no_nesting: assert property (stack_push |=> !stack_push) else $error("nested take");
    a_vector_range: assert property (s_enter |-> pc_load_value[1:0] == 2'h0 && pc_load_value <= VEC_TOP) else $error("bad vector");
    a_wake_asleep: assert property (wake_up |-> $past(sleep_mode)) else $error("wake while awake");
    a_read_upper: assert property (rvalid |-> rdata[31:8] == 24'h0) else $error("upper read bits set");
endmodule // irq_controller_props
bind irq_controller irq_controller_props #(.PC_W(PC_W)) i_irq_controller_props (.aclk, .aresetn, .rvalid, .rdata,
    .irq_ready, .stack_full, .pc_next, .return_from_irq, .stack_top, .sleep_mode, .stack_push, .push_pc, .stack_pop,
    .pc_load, .pc_load_value, .wake_up);
`default_nettype wire

//--- verif/tb.sv
// self-checking bench: register access, source events, vector takes
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb;
    logic aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
    logic sleep_mode = '0, do_ret = '0, slow = '0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [15:0] ev = '0, last_vec;
    logic [1:0] pn = '0, fs = 2'h3, di = 2'h3;
    wire logic awready, wready, bvalid, arready, rvalid, irq_ready, stack_full, return_from_irq;
    wire logic stack_push, stack_pop, pc_load, wake_up;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [15:0] pc_next, stack_top, push_pc, pc_load_value;
    int err_total = 0, checks = 0, push_cnt = 0, wake_cnt = 0;
    logic [7:0] mk [8] = '{8'h7E, 8'hFF, 8'hFF, 8'h33, 8'hFF, 8'h77, 8'h33, 8'h0F};
    logic [7:0] fl [7] = '{8'h40, 8'h90, 8'h60, 8'h30, 8'hF0, 8'h70, 8'h30};
    irq_controller i_irq_controller (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
        .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .ext_pin_a(pn[0]), .ext_pin_b(pn[1]), .pin_a_func_sel(fs[0]),
        .pin_b_func_sel(fs[1]), .pin_a_dir_in(di[0]), .pin_b_dir_in(di[1]), .touch_event(ev[0]),
        .serial_port_event(ev[1]), .converter_event(ev[2]), .timebase0_event(ev[3]), .timebase1_event(ev[4]),
        .compact0_match_a(ev[5]), .compact0_match_p(ev[6]), .compact1_match_a(ev[7]), .compact1_match_p(ev[8]),
        .standard_match_a(ev[9]), .standard_match_p(ev[10]), .periodic_match_a(ev[11]), .periodic_match_p(ev[12]),
        .serial_iface_event(ev[13]), .eeprom_write_event(ev[14]), .low_volt_event(ev[15]), .irq_ready, .stack_full,
        .pc_next, .return_from_irq, .stack_top, .sleep_mode, .stack_push, .push_pc, .stack_pop, .pc_load,
        .pc_load_value, .wake_up);
    cpu_seq_model i_cpu_seq_model (.aclk, .aresetn, .stack_push, .stack_pop, .pc_load, .push_pc, .pc_load_value,
        .do_ret, .slow, .irq_ready, .stack_full, .pc_next, .return_from_irq, .stack_top);
    always #20 aclk = ~aclk;
    // count takes and wakes
    always @(posedge aclk) begin
        if (stack_push) begin
            push_cnt++;
            last_vec = pc_load_value;
        end
        if (wake_up) wake_cnt++;
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic fail_wait();
        err_total++;
        $display("MISMATCH wait exp done got timeout");
        end_of_test();
    endtask
    function automatic logic [15:0] vec(input int i);
        return 16'(irq_ctrl_pkg::VEC_BASE + irq_ctrl_pkg::VEC_STEP * i);
    endfunction
    // axi write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        logic pa, pw;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        pa = 1'h1;
        pw = 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (pa && awready) begin
                pa = 1'h0;
                awvalid <= 1'h0;
            end
            if (pw && wready) begin
                pw = 1'h0;
                wvalid <= 1'h0;
            end
            if (!pa && !pw && bvalid) break;
        end
        bready <= 1'h0;
        if (n >= 50) fail_wait();
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic pa;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        pa = 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (pa && arready) begin
                pa = 1'h0;
                arvalid <= 1'h0;
            end else if (!pa && rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        if (n >= 50) fail_wait();
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        `CHK("reg", {24'h0, e}, d)
    endtask
    task automatic pulse(input logic [15:0] m);
        @(posedge aclk);
        ev <= m;
        @(posedge aclk);
        ev <= '0;
    endtask
    task automatic ret();
        @(posedge aclk);
        do_ret <= 1'h1;
        @(posedge aclk);
        do_ret <= 1'h0;
    endtask
    task automatic wait_push(input int c0);
        int n;
        for (n = 0; n < 40 && push_cnt == c0; n++) @(negedge aclk);
        if (n >= 40) fail_wait();
    endtask
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        // reset values, implemented bits, refused unmapped read
        for (int i = 0; i < 8; i++) rc(8'(4 * i), 8'h00);
        rd(8'h20, d, r);
        `CHK("resp", irq_ctrl_pkg::RESP_SLVERR, r)
        for (int i = 0; i < 8; i++) begin
            wr(8'(4 * i), i ? 8'hFF : 8'hFE);
            rc(8'(4 * i), mk[i]);
            wr(8'(4 * i), 8'h00);
        end
        // every event sets its flag with enables off; groups stay quiet
        pulse(16'hFFFF);
        for (int i = 0; i < 7; i++) rc(8'(4 * i), fl[i]);
        for (int i = 0; i < 7; i++) wr(8'(4 * i), 8'h00);
        // gated by global enable, then priority, stack full
        wr(8'h04, 8'h09);
        pulse(16'h0006);
        repeat (5) @(negedge aclk);
        `CHK("takes", 0, push_cnt)
        wr(8'h00, 8'h01);
        wait_push(0);
        `CHK("vec", vec(3), last_vec)
        rc(8'h00, 8'h00);
        rc(8'h04, 8'h89);
        slow <= 1'h1;
        wr(8'h00, 8'h01);
        repeat (8) @(negedge aclk);
        `CHK("takes", 1, push_cnt)
        ret();
        wait_push(1);
        `CHK("vec", vec(6), last_vec)
        ret();
        slow <= 1'h0;
        wr(8'h04, 8'h00);
        // each edge code against a rising then a falling edge on pin a
        for (int c = 0; c < 4; c++) begin
            wr(8'h1C, 8'(c));
            for (int e = 0; e < 2; e++) begin
                wr(8'h00, 8'h02);
                @(posedge aclk) pn[0] <= ~pn[0];
                rc(8'h00, (e ? c[1] : c[0]) ? 8'h12 : 8'h02);
            end
        end
        wr(8'h00, 8'h02);
        fs[0] <= 1'h0;
        @(posedge aclk) pn[0] <= ~pn[0];
        rc(8'h00, 8'h02);
        // a new flag wakes the sleeping core, a flag already set does not
        sleep_mode <= 1'h1;
        pulse(16'h0008);
        repeat (3) @(negedge aclk);
        `CHK("wake", 1, wake_cnt)
        pulse(16'h0008);
        repeat (3) @(negedge aclk);
        `CHK("wake", 1, wake_cnt)
        sleep_mode <= 1'h0;
        // enabled group source: service clears the group flag, not the source
        wr(8'h18, 8'h01);
        wr(8'h08, 8'h08);
        pulse(16'h8000);
        rc(8'h08, 8'h88);
        wr(8'h00, 8'h01);
        wait_push(2);
        `CHK("vec", vec(10), last_vec)
        rc(8'h08, 8'h08);
        rc(8'h18, 8'h11);
        ret();
        end_of_test();
    end
endmodule // tb
`default_nettype wire

//--- verilog/irq_controller.sv
// interrupt controller with axi4-lite register slave and cpu vector port
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module irq_controller #(
    parameter int PC_W = 16,
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // external pins and their port setup
    input wire logic ext_pin_a,
    input wire logic ext_pin_b,
    input wire logic pin_a_func_sel,
    input wire logic pin_b_func_sel,
    input wire logic pin_a_dir_in,
    input wire logic pin_b_dir_in,
    // peripheral event pulses
    input wire logic touch_event,
    input wire logic serial_port_event,
    input wire logic converter_event,
    input wire logic timebase0_event,
    input wire logic timebase1_event,
    input wire logic compact0_match_a,
    input wire logic compact0_match_p,
    input wire logic compact1_match_a,
    input wire logic compact1_match_p,
    input wire logic standard_match_a,
    input wire logic standard_match_p,
    input wire logic periodic_match_a,
    input wire logic periodic_match_p,
    input wire logic serial_iface_event,
    input wire logic eeprom_write_event,
    input wire logic low_volt_event,
    // cpu sequencer side
    input wire logic irq_ready,
    input wire logic stack_full,
    input wire logic [PC_W-1:0] pc_next,
    input wire logic return_from_irq,
    input wire logic [PC_W-1:0] stack_top,
    input wire logic sleep_mode,
    output logic stack_push,
    output logic [PC_W-1:0] push_pc,
    output logic stack_pop,
    output logic pc_load,
    output logic [PC_W-1:0] pc_load_value,
    output logic wake_up
);

    typedef struct packed {
        logic [7:0] c0;
        logic [7:0] c1;
        logic [7:0] c2;
        logic [7:0] g0;
        logic [7:0] g1;
        logic [7:0] g2;
        logic [7:0] g3;
        logic [7:0] es;
        logic pa;
        logic pb;
        logic aw_hold;
        logic w_hold;
        logic [ADDR_W-1:0] aw_addr;
        logic [7:0] w_byte;
        logic w_lane;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic push;
        logic pop;
        logic load;
        logic wake;
        logic [PC_W-1:0] push_pc;
        logic [PC_W-1:0] load_pc;
    } state_type;

    state_type s_q;
    state_type s_d;

    // one-hot byte for a bit position
    function automatic logic [7:0] bit_of(input int pos);
        bit_of = 8'h01 << pos;
    endfunction

    // edge detector for one pin under its edge-select code
    function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
        case (sel)
            irq_ctrl_pkg::EDGE_RISE: edge_hit = ~prev & cur;
            irq_ctrl_pkg::EDGE_FALL: edge_hit = prev & ~cur;
            irq_ctrl_pkg::EDGE_BOTH: edge_hit = prev ^ cur;
            default: edge_hit = 1'b0;
        endcase
    endfunction

    // register read decode: {hit, data}
    function automatic logic [8:0] reg_read(input logic [ADDR_W-1:0] a, input state_type s);
        case (8'(a))
            irq_ctrl_pkg::OFF_CTRL0: reg_read = {1'b1, s.c0};
            irq_ctrl_pkg::OFF_CTRL1: reg_read = {1'b1, s.c1};
            irq_ctrl_pkg::OFF_CTRL2: reg_read = {1'b1, s.c2};
            irq_ctrl_pkg::OFF_GRP0: reg_read = {1'b1, s.g0};
            irq_ctrl_pkg::OFF_GRP1: reg_read = {1'b1, s.g1};
            irq_ctrl_pkg::OFF_GRP2: reg_read = {1'b1, s.g2};
            irq_ctrl_pkg::OFF_GRP3: reg_read = {1'b1, s.g3};
            irq_ctrl_pkg::OFF_EDGE: reg_read = {1'b1, s.es};
            default: reg_read = 9'h000;
        endcase
    endfunction

    // next register value: write, then service clear, then hardware set wins
    function automatic logic [7:0] reg_next(input logic [7:0] cur, input logic wr, input logic [7:0] wv,
                                            input logic [7:0] clr, input logic [7:0] set,
                                            input logic [7:0] mask);
        reg_next = (((wr ? wv : cur) & ~clr) | set) & mask;
    endfunction

    // any enabled source flag newly raised inside a group
    function automatic logic group_hit(input logic [7:0] set, input logic [7:0] cur);
        group_hit = |(set[7:4] & cur[3:0]);
    endfunction

    localparam int NUM_W = irq_ctrl_pkg::NUM_SRC;

    logic pa_act;
    logic pb_act;
    logic pa_hit;
    logic pb_hit;
    logic [7:0] set0;
    logic [7:0] set1;
    logic [7:0] set2;
    logic [7:0] gs0;
    logic [7:0] gs1;
    logic [7:0] gs2;
    logic [7:0] gs3;
    logic [7:0] clr0;
    logic [7:0] clr1;
    logic [7:0] clr2;
    logic [NUM_W-1:0] flags;
    logic [NUM_W-1:0] enables;
    logic [NUM_W-1:0] pend;
    logic [NUM_W-1:0] win;
    logic [3:0] win_idx;
    logic take;
    logic wr_now;
    logic [8:0] wr_dec;
    logic [8:0] rd_dec;
    logic [7:0] wsel;

    // external pin qualification and edge detection
    always_comb begin
        pa_act = s_q.c0[irq_ctrl_pkg::B_PA_EN] & pin_a_func_sel & pin_a_dir_in;
        pb_act = s_q.c0[irq_ctrl_pkg::B_PB_EN] & pin_b_func_sel & pin_b_dir_in;
        pa_hit = pa_act & edge_hit(s_q.es[irq_ctrl_pkg::B_EDGE_A +: 2], s_q.pa, ext_pin_a);
        pb_hit = pb_act & edge_hit(s_q.es[irq_ctrl_pkg::B_EDGE_B +: 2], s_q.pb, ext_pin_b);
    end

    // hardware set vectors for every flag; pin flags need their pin enable, group flags an enabled group source
    always_comb begin
        gs0 = ({8{compact0_match_p}} & bit_of(irq_ctrl_pkg::B_MP + irq_ctrl_pkg::B_FLAG_OFS))
            | ({8{compact0_match_a}} & bit_of(irq_ctrl_pkg::B_MA + irq_ctrl_pkg::B_FLAG_OFS));
        gs1 = ({8{compact1_match_p}} & bit_of(irq_ctrl_pkg::B_MP + irq_ctrl_pkg::B_FLAG_OFS))
            | ({8{compact1_match_a}} & bit_of(irq_ctrl_pkg::B_MA + irq_ctrl_pkg::B_FLAG_OFS))
            | ({8{standard_match_p}} & bit_of(irq_ctrl_pkg::B_STD_P + irq_ctrl_pkg::B_FLAG_OFS))
            | ({8{standard_match_a}} & bit_of(irq_ctrl_pkg::B_STD_A + irq_ctrl_pkg::B_FLAG_OFS));
        gs2 = ({8{periodic_match_p}} & bit_of(irq_ctrl_pkg::B_MP + irq_ctrl_pkg::B_FLAG_OFS))
            | ({8{periodic_match_a}} & bit_of(irq_ctrl_pkg::B_MA + irq_ctrl_pkg::B_FLAG_OFS))
            | ({8{serial_iface_event}} & bit_of(irq_ctrl_pkg::B_SIM + irq_ctrl_pkg::B_FLAG_OFS));
        gs3 = ({8{low_volt_event}} & bit_of(irq_ctrl_pkg::B_LV + irq_ctrl_pkg::B_FLAG_OFS))
            | ({8{eeprom_write_event}} & bit_of(irq_ctrl_pkg::B_EE + irq_ctrl_pkg::B_FLAG_OFS));
        set0 = ({8{pa_hit}} & bit_of(irq_ctrl_pkg::B_PA_F))
             | ({8{pb_hit}} & bit_of(irq_ctrl_pkg::B_PB_F))
             | ({8{touch_event}} & bit_of(irq_ctrl_pkg::B_TK_F));
        set1 = ({8{serial_port_event}} & bit_of(irq_ctrl_pkg::B_UR_F))
             | ({8{group_hit(gs0, s_q.g0)}} & bit_of(irq_ctrl_pkg::B_G0_F))
             | ({8{group_hit(gs1, s_q.g1)}} & bit_of(irq_ctrl_pkg::B_G1_F))
             | ({8{converter_event}} & bit_of(irq_ctrl_pkg::B_AD_F));
        set2 = ({8{group_hit(gs2, s_q.g2)}} & bit_of(irq_ctrl_pkg::B_G2_F))
             | ({8{timebase0_event}} & bit_of(irq_ctrl_pkg::B_TB0_F))
             | ({8{timebase1_event}} & bit_of(irq_ctrl_pkg::B_TB1_F))
             | ({8{group_hit(gs3, s_q.g3)}} & bit_of(irq_ctrl_pkg::B_G3_F));
    end

    // flags and enables gathered in vector order
    always_comb begin
        // index 0 is pin a, index 10 is group three
        flags = {s_q.c2[irq_ctrl_pkg::B_G2_F +: 4],
                 s_q.c1[irq_ctrl_pkg::B_UR_F +: 4],
                 s_q.c0[irq_ctrl_pkg::B_PA_F +: 3]};
        // enables sit in the same order below the flags
        enables = {s_q.c2[irq_ctrl_pkg::B_G2_EN +: 4],
                   s_q.c1[irq_ctrl_pkg::B_UR_EN +: 4],
                   s_q.c0[irq_ctrl_pkg::B_PA_EN +: 3]};
        pend = flags & enables;
        // a pin with edge select disabled never vectors
        if (s_q.es[irq_ctrl_pkg::B_EDGE_A +: 2] == irq_ctrl_pkg::EDGE_OFF) begin
            pend[0] = 1'b0;
        end
        if (s_q.es[irq_ctrl_pkg::B_EDGE_B +: 2] == irq_ctrl_pkg::EDGE_OFF) begin
            pend[1] = 1'b0;
        end
    end

    // arbitration: lowest vector index wins
    always_comb begin
        win = '0;
        win_idx = 4'h0;
        for (int i = NUM_W - 1; i >= 0; i--) begin
            if (pend[i]) begin
                win = '0;
                win[i] = 1'b1;
                win_idx = 4'(i);
            end
        end
        take = s_q.c0[irq_ctrl_pkg::B_GIE] & ~stack_full & irq_ready & (|pend)
             & ~return_from_irq & ~s_q.load;
        if (!take) begin
            win = '0;
        end
    end

    // service clears: winner flag plus global enable
    always_comb begin
        clr0 = ({8{take}} & bit_of(irq_ctrl_pkg::B_GIE))
             | ({8{win[0]}} & bit_of(irq_ctrl_pkg::B_PA_F))
             | ({8{win[1]}} & bit_of(irq_ctrl_pkg::B_PB_F))
             | ({8{win[2]}} & bit_of(irq_ctrl_pkg::B_TK_F));
        clr1 = ({8{win[3]}} & bit_of(irq_ctrl_pkg::B_UR_F))
             | ({8{win[4]}} & bit_of(irq_ctrl_pkg::B_G0_F))
             | ({8{win[5]}} & bit_of(irq_ctrl_pkg::B_G1_F))
             | ({8{win[6]}} & bit_of(irq_ctrl_pkg::B_AD_F));
        clr2 = ({8{win[7]}} & bit_of(irq_ctrl_pkg::B_G2_F))
             | ({8{win[8]}} & bit_of(irq_ctrl_pkg::B_TB0_F))
             | ({8{win[9]}} & bit_of(irq_ctrl_pkg::B_TB1_F))
             | ({8{win[10]}} & bit_of(irq_ctrl_pkg::B_G3_F));
    end

    // bus write decode
    always_comb begin
        wr_now = s_q.aw_hold & s_q.w_hold & ~s_q.bvalid;
        wr_dec = reg_read(s_q.aw_addr, s_q);
        rd_dec = reg_read(araddr, s_q);
        wsel = '0;
        case (8'(s_q.aw_addr))
            irq_ctrl_pkg::OFF_CTRL0: wsel[0] = 1'b1;
            irq_ctrl_pkg::OFF_CTRL1: wsel[1] = 1'b1;
            irq_ctrl_pkg::OFF_CTRL2: wsel[2] = 1'b1;
            irq_ctrl_pkg::OFF_GRP0: wsel[3] = 1'b1;
            irq_ctrl_pkg::OFF_GRP1: wsel[4] = 1'b1;
            irq_ctrl_pkg::OFF_GRP2: wsel[5] = 1'b1;
            irq_ctrl_pkg::OFF_GRP3: wsel[6] = 1'b1;
            irq_ctrl_pkg::OFF_EDGE: wsel[7] = 1'b1;
            default: wsel = '0;
        endcase
        wsel = wsel & {8{wr_now & s_q.w_lane}};
    end

    // next state
    always_comb begin
        s_d = s_q;
        s_d.pa = ext_pin_a;
        s_d.pb = ext_pin_b;
        s_d.push = 1'b0;
        s_d.pop = 1'b0;
        s_d.load = 1'b0;
        // registers: write, service clear, then event set wins
        s_d.c0 = reg_next(s_q.c0, wsel[0], s_q.w_byte, clr0, set0, irq_ctrl_pkg::MASK_CTRL0);
        s_d.c1 = reg_next(s_q.c1, wsel[1], s_q.w_byte, clr1, set1, irq_ctrl_pkg::MASK_CTRL1);
        s_d.c2 = reg_next(s_q.c2, wsel[2], s_q.w_byte, clr2, set2, irq_ctrl_pkg::MASK_CTRL2);
        s_d.g0 = reg_next(s_q.g0, wsel[3], s_q.w_byte, 8'h00, gs0, irq_ctrl_pkg::MASK_GRP0);
        s_d.g1 = reg_next(s_q.g1, wsel[4], s_q.w_byte, 8'h00, gs1, irq_ctrl_pkg::MASK_GRP1);
        s_d.g2 = reg_next(s_q.g2, wsel[5], s_q.w_byte, 8'h00, gs2, irq_ctrl_pkg::MASK_GRP2);
        s_d.g3 = reg_next(s_q.g3, wsel[6], s_q.w_byte, 8'h00, gs3, irq_ctrl_pkg::MASK_GRP3);
        s_d.es = reg_next(s_q.es, wsel[7], s_q.w_byte, 8'h00, 8'h00, irq_ctrl_pkg::MASK_EDGE);
        // wake only on a flag that goes from clear to set by an event
        s_d.wake = sleep_mode & (|((set0 & ~s_q.c0) | (set1 & ~s_q.c1) | (set2 & ~s_q.c2)
                 | (gs0 & ~s_q.g0) | (gs1 & ~s_q.g1) | (gs2 & ~s_q.g2) | (gs3 & ~s_q.g3)));
        // vector entry and return
        if (return_from_irq) begin
            s_d.pop = 1'b1;
            s_d.load = 1'b1;
            s_d.load_pc = stack_top;
        end else if (take) begin
            s_d.push = 1'b1;
            s_d.push_pc = pc_next;
            s_d.load = 1'b1;
            s_d.load_pc = PC_W'(irq_ctrl_pkg::VEC_BASE + int'(win_idx) * irq_ctrl_pkg::VEC_STEP);
        end
        // write address and data channels, taken in either order
        if (awvalid && s_q.awready) begin
            s_d.aw_hold = 1'b1;
            s_d.aw_addr = awaddr;
        end
        if (wvalid && s_q.wready) begin
            s_d.w_hold = 1'b1;
            s_d.w_byte = wdata[7:0];
            s_d.w_lane = wstrb[0];
        end
        if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end
        if (wr_now) begin
            s_d.aw_hold = 1'b0;
            s_d.w_hold = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = wr_dec[8] ? irq_ctrl_pkg::RESP_OKAY : irq_ctrl_pkg::RESP_SLVERR;
        end
        s_d.awready = ~s_d.aw_hold & ~s_d.bvalid;
        s_d.wready = ~s_d.w_hold & ~s_d.bvalid;
        // read channel
        if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end
        if (arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_dec[7:0];
            s_d.rresp = rd_dec[8] ? irq_ctrl_pkg::RESP_OKAY : irq_ctrl_pkg::RESP_SLVERR;
        end
        s_d.arready = ~s_d.rvalid;
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.c0 <= irq_ctrl_pkg::RESET_VAL;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state flops
    assign awready = s_q.awready;
    assign wready = s_q.wready;
    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign arready = s_q.arready;
    assign rvalid = s_q.rvalid;
    assign rresp = s_q.rresp;
    assign rdata = {24'h000000, s_q.rdata};
    assign stack_push = s_q.push;
    assign push_pc = s_q.push_pc;
    assign stack_pop = s_q.pop;
    assign pc_load = s_q.load;
    assign pc_load_value = s_q.load_pc;
    assign wake_up = s_q.wake;

endmodule // irq_controller
`default_nettype wire

//--- verilog/irq_ctrl_pkg.sv
// constants for the interrupt controller: offsets, field positions, encodings
package irq_ctrl_pkg;
    // register byte addresses
    localparam logic [7:0] OFF_CTRL0 = 8'h00;
    localparam logic [7:0] OFF_CTRL1 = 8'h04;
    localparam logic [7:0] OFF_CTRL2 = 8'h08;
    localparam logic [7:0] OFF_GRP0 = 8'h0C;
    localparam logic [7:0] OFF_GRP1 = 8'h10;
    localparam logic [7:0] OFF_GRP2 = 8'h14;
    localparam logic [7:0] OFF_GRP3 = 8'h18;
    localparam logic [7:0] OFF_EDGE = 8'h1C;
    localparam logic [7:0] RESET_VAL = 8'h00;
    // implemented bits per register
    localparam logic [7:0] MASK_CTRL0 = 8'h7F;
    localparam logic [7:0] MASK_CTRL1 = 8'hFF;
    localparam logic [7:0] MASK_CTRL2 = 8'hFF;
    localparam logic [7:0] MASK_GRP0 = 8'h33;
    localparam logic [7:0] MASK_GRP1 = 8'hFF;
    localparam logic [7:0] MASK_GRP2 = 8'h77;
    localparam logic [7:0] MASK_GRP3 = 8'h33;
    localparam logic [7:0] MASK_EDGE = 8'h0F;
    // control zero fields
    localparam int B_GIE = 0;
    localparam int B_PA_EN = 1;
    localparam int B_PB_EN = 2;
    localparam int B_TK_EN = 3;
    localparam int B_PA_F = 4;
    localparam int B_PB_F = 5;
    localparam int B_TK_F = 6;
    // control one fields
    localparam int B_UR_EN = 0;
    localparam int B_G0_EN = 1;
    localparam int B_G1_EN = 2;
    localparam int B_AD_EN = 3;
    localparam int B_UR_F = 4;
    localparam int B_G0_F = 5;
    localparam int B_G1_F = 6;
    localparam int B_AD_F = 7;
    // control two fields
    localparam int B_G2_EN = 0;
    localparam int B_TB0_EN = 1;
    localparam int B_TB1_EN = 2;
    localparam int B_G3_EN = 3;
    localparam int B_G2_F = 4;
    localparam int B_TB0_F = 5;
    localparam int B_TB1_F = 6;
    localparam int B_G3_F = 7;
    // group fields: flag sits at enable position plus four
    localparam int B_FLAG_OFS = 4;
    localparam int B_MP = 0;
    localparam int B_MA = 1;
    localparam int B_STD_P = 2;
    localparam int B_STD_A = 3;
    localparam int B_SIM = 2;
    localparam int B_LV = 0;
    localparam int B_EE = 1;
    // edge select field positions and codes
    localparam int B_EDGE_A = 0;
    localparam int B_EDGE_B = 2;
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // sources in vector (and priority) order
    localparam int NUM_SRC = 11;
    localparam int VEC_BASE = 4;
    localparam int VEC_STEP = 4;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
